/* File: design/rxdlb_pkg.sv */
// shared constants and carrier types for the receive data link / backplane output block
package rxdlb_pkg;

	// register bus layout
	localparam int           ADR_W          = 8;
	localparam int           DAT_W          = 32;
	localparam logic [7:0]   ADR_CTRL       = 8'h00;
	localparam logic [7:0]   ADR_STAT       = 8'h04;
	localparam logic [31:0]  CTRL_RESET     = 32'h0000_0000;
	localparam int           CFG_W          = 7;
	localparam int           STAT_W         = 4;
	localparam int           STAT_IRQ       = 0;
	localparam int           STAT_EOM       = 1;
	localparam int           STAT_DL_VALID  = 2;
	localparam int           STAT_BP_VALID  = 3;
	localparam int           CLR_W          = 2;

	// clock period of CLK_IN in ns
	localparam int           CLK_PERIOD_NS  = 50;

	typedef enum logic [1:0] {
		RXDLB_FMT_SF      = 2'b00,
		RXDLB_FMT_ESF     = 2'b01,
		RXDLB_FMT_T1DM    = 2'b10,
		RXDLB_FMT_SUBLOOP = 2'b11
	} rxdlb_fmt_t;

	// control word, msb first: bit 6 down to bit 0
	typedef struct packed {
		logic       elastic_store_bypass;
		logic       bp_dual;
		logic       out_en;
		logic       dchan_en;
		logic       hdlc_en;
		rxdlb_fmt_t fmt;
	} rxdlb_cfg_t;

	// pins and strobes arriving from the line and backplane timing domains
	typedef struct packed {
		logic bp_clk;
		logic line_clk;
		logic fdl_bit;
		logic rbit;
		logic fs_bit;
		logic ch24_bit;
		logic dl_slot;
		logic ch24_slot;
		logic pcm;
		logic sig;
		logic sig_slot;
		logic pos;
		logic neg;
	} rxdlb_pins_t;

	// events from the hdlc receiver, same clock as this block
	typedef struct packed {
		logic status_evt;
		logic last_byte_read;
		logic overrun;
	} rxdlb_hdlc_evt_t;

endpackage : rxdlb_pkg

/* File: design/rxdlb_sync.sv */
// two-stage synchroniser for the asynchronous pin group
`timescale 1ns/1ns
module rxdlb_sync
	import rxdlb_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// pins
	input  wire rxdlb_pins_t pins_in,
	output rxdlb_pins_t      pins_out
);

	typedef struct packed {
		rxdlb_pins_t stage1;
		rxdlb_pins_t stage2;
	} rxdlb_sync_st_t;

	rxdlb_sync_st_t st_reg;
	rxdlb_sync_st_t st_next;

	// stage1 feeds stage2 only
	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = pins_in;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pins_out = st_reg.stage2;

endmodule : rxdlb_sync

/* File: design/rxdlb_top.sv */
// receive data link and backplane output stage
//
// Behaviour
// (R1) ESF: data link output carries the extracted facility data link while hdlc is off.
// (R2) SF: data link output held low.
// (R3) T1DM: data link output carries the sync word R-bit.
// (R4) subscriber loop format: data link output carries the Fs framing bits.
// (R5) D-channel extraction: channel 24 bits go out with their clock.
// (R6) data link output changes only on the falling edge of its clock.
// (R7) consumer samples data link output on the rising clock edge, except SF.
// (R8) SF: data link clock held low.
// (R9) data link pins driven only with hdlc off or D-channel extraction selected.
// (R10) hdlc on: data pin is interrupt, high on any hdlc status event.
// (R11) hdlc on: clock pin is end of message, high on last byte read or overrun.
// (R12) single rail: pcm output is the fully processed receive stream.
// (R13) elastic store used: pcm updates on backplane clock falling edges.
// (R14) elastic store bypassed: pcm updates on line clock falling edges.
// (R15) single rail: signalling in channel bits 5 to 8, aligned with pcm.
// (R16) signalling output timed exactly like the pcm output.
// (R17) dual rail: positive pulses on positive rail, line clock falling edges.
// (R18) dual rail: negative pulses on negative rail, line clock falling edges.
// (R19) backplane clock is 1.544 or 2.048 MHz, possibly gapped.
// (R20) recovered line clock is 1.544 MHz, synchronous to master clock.
// (R21) outputs low after reset until enabled and data has arrived.
`timescale 1ns/1ns
module rxdlb_top
	import rxdlb_pkg::*;
(
	// clock and reset
	input  wire logic              CLK_IN,
	input  wire logic              RST_B_IN,
	// wishbone
	input  wire logic              WB_CYC_IN,
	input  wire logic              WB_STB_IN,
	input  wire logic              WB_WE_IN,
	input  wire logic [ADR_W-1:0]  WB_ADR_IN,
	input  wire logic [3:0]        WB_SEL_IN,
	input  wire logic [DAT_W-1:0]  WB_DAT_IN,
	output logic                   WB_ACK_OUT,
	output logic [DAT_W-1:0]       WB_DAT_OUT,
	// line and backplane timing, asynchronous
	input  wire logic              BP_RX_CLOCK_IN,
	input  wire logic              RECOVERED_LINE_CLOCK_IN,
	// data link sources, line timing
	input  wire logic              FDL_BIT_IN,
	input  wire logic              RBIT_IN,
	input  wire logic              FS_BIT_IN,
	input  wire logic              CH24_BIT_IN,
	input  wire logic              DL_SLOT_IN,
	input  wire logic              CH24_SLOT_IN,
	// backplane sources
	input  wire logic              PCM_IN,
	input  wire logic              SIG_IN,
	input  wire logic              SIG_SLOT_IN,
	input  wire logic              POS_PULSE_IN,
	input  wire logic              NEG_PULSE_IN,
	// hdlc receiver events, same clock
	input  wire rxdlb_hdlc_evt_t   HDLC_EVT_IN,
	// shared data link pins
	output logic                   DL_SERIAL_OUT,
	output logic                   DL_CLOCK_OUT,
	// backplane pins
	output logic                   BP_RX_PCM_OUT,
	output logic                   BP_RX_SIGNALLING_OUT
);

	typedef struct packed {
		logic bp_clk_prev;
		logic line_clk_prev;
		logic dl_data;
		logic dl_clk;
		logic dl_armed;
		logic dl_valid;
		logic irq;
		logic eom;
		logic bp_a;
		logic bp_b;
		logic bp_valid;
		logic pin_data;
		logic pin_clk;
	} rxdlb_top_st_t;

	// modes decoded once from the control word
	typedef struct packed {
		logic dl_own;
		logic dl_silent;
		logic bp_line;
		logic hdlc_pins;
	} rxdlb_mode_t;

	rxdlb_top_st_t      st_reg;
	rxdlb_top_st_t      st_next;
	logic [1:0]         rst_pipe_reg;
	logic               rst_b;
	rxdlb_pins_t        pins_raw;
	rxdlb_pins_t        pins;
	rxdlb_cfg_t         cfg;
	logic [CLR_W-1:0]   clr;
	logic [STAT_W-1:0]  status;
	logic               line_fall;
	logic               line_rise;
	logic               bp_fall;
	logic               dl_take;
	logic               dl_pins_own;
	logic               dl_silent;
	rxdlb_mode_t        mode;

	// data link bit for the selected format
	function automatic logic dl_source(input rxdlb_cfg_t c, input rxdlb_pins_t p);
		logic b;
		b = 1'b0;
		if (c.dchan_en) begin
			b = p.ch24_bit; // R5
		end else begin
			unique case (c.fmt)
				RXDLB_FMT_SF:      b = 1'b0; // R2
				RXDLB_FMT_ESF:     b = p.fdl_bit; // R1
				RXDLB_FMT_T1DM:    b = p.rbit; // R3
				RXDLB_FMT_SUBLOOP: b = p.fs_bit; // R4
			endcase
		end
		return b;
	endfunction : dl_source

	// edges seen between the held sample and the synchronised pin
	function automatic logic edge_fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction : edge_fell

	function automatic logic edge_rose(input logic prev, input logic cur);
		return ~prev & cur;
	endfunction : edge_rose

	// hdlc owns the shared pins only while d-channel extraction is off
	function automatic rxdlb_mode_t mode_of(input rxdlb_cfg_t c);
		rxdlb_mode_t m;
		m           = '0;
		m.dl_own    = ~c.hdlc_en | c.dchan_en; // R9
		m.dl_silent = ~c.out_en | (c.fmt == RXDLB_FMT_SF && !c.dchan_en); // R2 R8
		m.bp_line   = c.elastic_store_bypass | c.bp_dual; // R14 R17 R18
		m.hdlc_pins = c.out_en & ~m.dl_own; // R10 R11
		return m;
	endfunction : mode_of

	// backplane bit pair for the selected rail mode
	function automatic logic [1:0] bp_source(input rxdlb_cfg_t c, input rxdlb_pins_t p);
		logic [1:0] r;
		if (c.bp_dual) begin
			r = {p.pos, p.neg}; // R17 R18
		end else begin
			r = {p.pcm, p.sig & p.sig_slot}; // R12 R15
		end
		return r;
	endfunction : bp_source

	// reset released through two flops
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_b = rst_pipe_reg[1];

	assign pins_raw = '{
		bp_clk:    BP_RX_CLOCK_IN,
		line_clk:  RECOVERED_LINE_CLOCK_IN,
		fdl_bit:   FDL_BIT_IN,
		rbit:      RBIT_IN,
		fs_bit:    FS_BIT_IN,
		ch24_bit:  CH24_BIT_IN,
		dl_slot:   DL_SLOT_IN,
		ch24_slot: CH24_SLOT_IN,
		pcm:       PCM_IN,
		sig:       SIG_IN,
		sig_slot:  SIG_SLOT_IN,
		pos:       POS_PULSE_IN,
		neg:       NEG_PULSE_IN
	};

	// clocks and data share one delay, so their phase relation is kept
	rxdlb_sync u_sync (
		.clk_in   (CLK_IN),
		.rst_b_in (rst_b),
		.pins_in  (pins_raw),
		.pins_out (pins)
	);

	// control word and status view
	rxdlb_wb u_wb (
		.clk_in    (CLK_IN),
		.rst_b_in  (rst_b),
		.cyc_in    (WB_CYC_IN),
		.stb_in    (WB_STB_IN),
		.we_in     (WB_WE_IN),
		.adr_in    (WB_ADR_IN),
		.sel_in    (WB_SEL_IN),
		.dat_in    (WB_DAT_IN),
		.ack_out   (WB_ACK_OUT),
		.dat_out   (WB_DAT_OUT),
		.status_in (status),
		.cfg_out   (cfg),
		.clr_out   (clr)
	);

	// status word: sticky hdlc flags and the output valid bits
	always_comb begin
		status                = '0;
		status[STAT_IRQ]      = st_reg.irq;
		status[STAT_EOM]      = st_reg.eom;
		status[STAT_DL_VALID] = st_reg.dl_valid;
		status[STAT_BP_VALID] = st_reg.bp_valid;
	end

	// 20 MHz sampling gives about six samples per half period at 1.544 MHz and about five at 2.048 MHz
	assign mode        = mode_of(cfg);
	assign line_fall   = edge_fell(st_reg.line_clk_prev, pins.line_clk); // R20
	assign line_rise   = edge_rose(st_reg.line_clk_prev, pins.line_clk);
	// a gapped backplane clock gives no edge, so nothing moves in a gap
	assign bp_fall     = mode.bp_line ? line_fall :
	                     edge_fell(st_reg.bp_clk_prev, pins.bp_clk); // R13 R14 R19
	assign dl_take     = cfg.dchan_en ? pins.ch24_slot : pins.dl_slot;
	assign dl_pins_own = mode.dl_own; // R9
	assign dl_silent   = mode.dl_silent;

	always_comb begin
		st_next               = st_reg;
		st_next.bp_clk_prev   = pins.bp_clk;
		st_next.line_clk_prev = pins.line_clk;

		// data link: data and clock fall together, clock rises mid bit
		// bits outside the slot leave the clock low, so it comes out gapped
		if (dl_silent) begin
			st_next.dl_data  = 1'b0; // R2 R21
			st_next.dl_clk   = 1'b0; // R8
			st_next.dl_armed = 1'b0;
			st_next.dl_valid = 1'b0;
		end else if (line_fall) begin
			st_next.dl_clk   = 1'b0; // R6
			st_next.dl_armed = dl_take;
			if (dl_take) begin
				st_next.dl_data  = dl_source(cfg, pins); // R1 R3 R4 R5
				st_next.dl_valid = 1'b1;
			end
		end else if (line_rise && st_reg.dl_armed) begin
			st_next.dl_clk = 1'b1; // R7
		end

		// hdlc flags: a new event beats a software clear
		if (clr[STAT_IRQ]) begin
			st_next.irq = 1'b0;
		end
		if (clr[STAT_EOM]) begin
			st_next.eom = 1'b0;
		end
		if (cfg.hdlc_en && HDLC_EVT_IN.status_evt) begin
			st_next.irq = 1'b1; // R10
		end
		if (cfg.hdlc_en && (HDLC_EVT_IN.last_byte_read || HDLC_EVT_IN.overrun)) begin
			st_next.eom = 1'b1; // R11
		end

		// shared pins
		// hdlc flags reach the pins only while the outputs are enabled
		if (dl_pins_own) begin
			st_next.pin_data = st_next.dl_data; // R9
			st_next.pin_clk  = st_next.dl_clk;
		end else begin
			st_next.pin_data = st_next.irq & mode.hdlc_pins; // R10
			st_next.pin_clk  = st_next.eom & mode.hdlc_pins; // R11
		end

		// backplane
		// outputs hold between edges, so a clock gap simply stretches a bit
		if (!cfg.out_en) begin
			st_next.bp_a     = 1'b0; // R21
			st_next.bp_b     = 1'b0;
			st_next.bp_valid = 1'b0;
		end else if (bp_fall) begin
			st_next.bp_valid = 1'b1;
			{st_next.bp_a, st_next.bp_b} = bp_source(cfg, pins); // R12 R13 R14 R16
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign DL_SERIAL_OUT        = st_reg.pin_data;
	assign DL_CLOCK_OUT         = st_reg.pin_clk;
	assign BP_RX_PCM_OUT        = st_reg.bp_a;
	assign BP_RX_SIGNALLING_OUT = st_reg.bp_b;

endmodule : rxdlb_top

/* File: design/rxdlb_wb.sv */
// classic wishbone slave holding the control word and status view
`timescale 1ns/1ns
module rxdlb_wb
	import rxdlb_pkg::*;
(
	// clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_b_in,
	// wishbone
	input  wire logic               cyc_in,
	input  wire logic               stb_in,
	input  wire logic               we_in,
	input  wire logic [ADR_W-1:0]   adr_in,
	input  wire logic [3:0]         sel_in,
	input  wire logic [DAT_W-1:0]   dat_in,
	output logic                    ack_out,
	output logic [DAT_W-1:0]        dat_out,
	// block side
	input  wire logic [STAT_W-1:0]  status_in,
	output rxdlb_cfg_t              cfg_out,
	output logic [CLR_W-1:0]        clr_out
);

	typedef struct packed {
		rxdlb_cfg_t       cfg;
		logic             ack;
		logic [DAT_W-1:0] dat;
		logic [CLR_W-1:0] clr;
	} rxdlb_wb_st_t;

	rxdlb_wb_st_t st_reg;
	rxdlb_wb_st_t st_next;
	logic         req;

	// ack drops the cycle after it rises, so a held request is taken at most every other cycle
	assign req = cyc_in & stb_in & ~st_reg.ack;

	always_comb begin
		st_next     = st_reg;
		st_next.ack = req;
		st_next.clr = '0;
		if (req) begin
			unique case (adr_in)
				ADR_CTRL: begin
					st_next.dat = {{(DAT_W-CFG_W){1'b0}}, st_reg.cfg};
					if (we_in && sel_in[0]) begin
						st_next.cfg = rxdlb_cfg_t'(dat_in[CFG_W-1:0]);
					end
				end
				ADR_STAT: begin
					st_next.dat = {{(DAT_W-STAT_W){1'b0}}, status_in};
					if (we_in && sel_in[0]) begin
						st_next.clr = dat_in[CLR_W-1:0];
					end
				end
				default: begin
					st_next.dat = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg     <= '0;
			st_reg.cfg <= rxdlb_cfg_t'(CTRL_RESET[CFG_W-1:0]);
		end else begin
			st_reg <= st_next;
		end
	end

	assign ack_out = st_reg.ack;
	assign dat_out = st_reg.dat;
	assign cfg_out = st_reg.cfg;
	assign clr_out = st_reg.clr;

endmodule : rxdlb_wb

/* File: sim/rxdlb_chk_sva.sv */
// assertion checker for the data link and backplane output stage
`timescale 1ns/1ns
module rxdlb_chk
	import rxdlb_pkg::*;
(
	// clock and reset
	input  wire logic             CLK_IN,
	input  wire logic             RST_B_IN,
	// wishbone
	input  wire logic             WB_CYC_IN,
	input  wire logic             WB_STB_IN,
	input  wire logic             WB_WE_IN,
	input  wire logic [ADR_W-1:0] WB_ADR_IN,
	input  wire logic [3:0]       WB_SEL_IN,
	input  wire logic [DAT_W-1:0] WB_DAT_IN,
	input  wire logic             WB_ACK_OUT,
	// timing and events
	input  wire logic             BP_RX_CLOCK_IN,
	input  wire logic             RECOVERED_LINE_CLOCK_IN,
	input  wire rxdlb_hdlc_evt_t  HDLC_EVT_IN,
	// outputs watched
	input  wire logic             DL_SERIAL_OUT,
	input  wire logic             DL_CLOCK_OUT,
	input  wire logic             BP_RX_PCM_OUT,
	input  wire logic             BP_RX_SIGNALLING_OUT
);
	rxdlb_cfg_t ctl_reg;
	logic [2:0] age_reg;
	logic       take;
	logic       dl_on;
	logic       hd_on;
	logic       sf_on;
	logic       bp_on;
	logic       ln_on;
	logic       off;
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	assign take = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT && WB_SEL_IN[0]
		&& WB_ADR_IN == ADR_CTRL;
	// judged only once the mode has stood for seven cycles
	assign dl_on = ctl_reg.out_en && age_reg == 3'h7
		&& (ctl_reg.dchan_en || (!ctl_reg.hdlc_en && ctl_reg.fmt != RXDLB_FMT_SF));
	assign hd_on = ctl_reg.out_en && age_reg == 3'h7 && ctl_reg.hdlc_en && !ctl_reg.dchan_en;
	assign sf_on = ctl_reg.out_en && age_reg == 3'h7 && ctl_reg[4:0] == 5'h10;
	assign bp_on = ctl_reg.out_en && age_reg == 3'h7 && ctl_reg[6:5] == 2'h0;
	assign ln_on = ctl_reg.out_en && age_reg == 3'h7 && ctl_reg[6:5] != 2'h0;
	assign off   = !ctl_reg.out_en && age_reg == 3'h7;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctl_reg <= rxdlb_cfg_t'(CTRL_RESET[CFG_W-1:0]);
			age_reg <= 3'h0;
		end else begin
			if (take) begin
				ctl_reg <= rxdlb_cfg_t'(WB_DAT_IN[CFG_W-1:0]);
			end
			age_reg <= take ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
		end
	end
	AST_OFF_LOW: assert property (off |-> !DL_SERIAL_OUT && !DL_CLOCK_OUT
		&& !BP_RX_PCM_OUT && !BP_RX_SIGNALLING_OUT) else $error("output active while off");
	AST_SF_HOLD: assert property (sf_on |-> !DL_SERIAL_OUT && !DL_CLOCK_OUT)
		else $error("data link pins not low in sf");
	AST_DL_CHANGE: assert property (dl_on && $changed(DL_SERIAL_OUT) |-> !DL_CLOCK_OUT)
		else $error("data changed while clock high");
	AST_DL_FALL: assert property (dl_on && $fell(RECOVERED_LINE_CLOCK_IN)
		|-> ##[2:4] !DL_CLOCK_OUT) else $error("data link clock did not fall");
	AST_DL_RISE: assert property (dl_on && $rose(DL_CLOCK_OUT) |-> RECOVERED_LINE_CLOCK_IN)
		else $error("data link clock rose off line timing");
	AST_IRQ: assert property (hd_on && HDLC_EVT_IN.status_evt |-> ##[1:2] DL_SERIAL_OUT)
		else $error("interrupt pin not raised");
	AST_EOM: assert property (hd_on && (HDLC_EVT_IN.last_byte_read || HDLC_EVT_IN.overrun)
		|-> ##[1:2] DL_CLOCK_OUT) else $error("end of message pin not raised");
	AST_BP_TIME: assert property (bp_on && $changed({BP_RX_PCM_OUT, BP_RX_SIGNALLING_OUT})
		|-> !BP_RX_CLOCK_IN) else $error("backplane output off backplane timing");
	AST_LN_TIME: assert property (ln_on && $changed({BP_RX_PCM_OUT, BP_RX_SIGNALLING_OUT})
		|-> !RECOVERED_LINE_CLOCK_IN) else $error("backplane output off line timing");
endmodule : rxdlb_chk

/* File: sim/rxdlb_far.sv */
// far side model: free line clock, gapped backplane clock and their data
`timescale 1ns/1ns
module rxdlb_far
	import rxdlb_pkg::*;
(
	// pcm timed by line clock when high
	input  wire logic  line_pcm_in,
	// pins towards the block
	output rxdlb_pins_t pins_out
);
	logic [7:0] n_reg;
	logic [7:0] m_reg;
	logic [3:0] gap_reg;
	initial begin
		pins_out = '0;
		n_reg = 8'h00;
		m_reg = 8'h5a;
		gap_reg = 4'h0;
	end
	// even half periods never meet a rising edge of the 50 ns clock
	always #324 pins_out.line_clk = ~pins_out.line_clk;
	always #244 begin
		gap_reg = gap_reg + 4'h1;
		if (gap_reg != 4'hf) pins_out.bp_clk = ~pins_out.bp_clk;
	end
	// data moves on rising edges so it stands still at every falling edge
	always @(posedge pins_out.line_clk) begin
		n_reg = n_reg * 8'h05 + 8'h03;
		{pins_out.fdl_bit, pins_out.rbit, pins_out.fs_bit, pins_out.ch24_bit} = n_reg[7:4];
		pins_out.dl_slot = n_reg[3] | n_reg[2];
		pins_out.ch24_slot = n_reg[2];
		pins_out.pos = n_reg[1] & ~n_reg[0];
		pins_out.neg = n_reg[0] & ~n_reg[1];
		if (line_pcm_in) {pins_out.pcm, pins_out.sig, pins_out.sig_slot} = n_reg[6:4];
	end
	always @(posedge pins_out.bp_clk) begin
		m_reg = m_reg * 8'h05 + 8'h01;
		if (!line_pcm_in) {pins_out.pcm, pins_out.sig, pins_out.sig_slot} = m_reg[7:5];
	end
endmodule : rxdlb_far

/* File: sim/rxdlb_test.sv */
// testbench for the data link and backplane output stage
`timescale 1ns/1ns
module rxdlb_test;
	import rxdlb_pkg::*;
	logic            clk = 1'b0;
	logic            rst_b = 1'b0;
	logic            cyc = 1'b0;
	logic            stb = 1'b0;
	logic            we = 1'b0;
	logic [7:0]      adr = 8'h00;
	logic [3:0]      sel = 4'h0;
	logic [31:0]     dat = 32'h0000_0000;
	logic            ack;
	logic [31:0]     rdat;
	logic [31:0]     rd;
	rxdlb_hdlc_evt_t evt = '0;
	logic            lp = 1'b0;
	rxdlb_pins_t     p;
	logic            dls;
	logic            dlc;
	logic            pcm;
	logic            sig;
	int              mismatches = 0;
	int              checks = 0;
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	rxdlb_far i_far (.line_pcm_in(lp), .pins_out(p));
	rxdlb_top i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_ACK_OUT(ack),
		.WB_DAT_OUT(rdat), .BP_RX_CLOCK_IN(p.bp_clk), .RECOVERED_LINE_CLOCK_IN(p.line_clk),
		.FDL_BIT_IN(p.fdl_bit), .RBIT_IN(p.rbit), .FS_BIT_IN(p.fs_bit), .CH24_BIT_IN(p.ch24_bit),
		.DL_SLOT_IN(p.dl_slot), .CH24_SLOT_IN(p.ch24_slot), .PCM_IN(p.pcm), .SIG_IN(p.sig),
		.SIG_SLOT_IN(p.sig_slot), .POS_PULSE_IN(p.pos), .NEG_PULSE_IN(p.neg),
		.HDLC_EVT_IN(evt), .DL_SERIAL_OUT(dls), .DL_CLOCK_OUT(dlc), .BP_RX_PCM_OUT(pcm),
		.BP_RX_SIGNALLING_OUT(sig));
	task automatic stop_test();
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1) begin
			mismatches++;
			stop_test();
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	// waits for a falling edge of the line or backplane clock pin
	task automatic fall(input logic bp);
		int i;
		logic c;
		logic q;
		q = bp ? p.bp_clk : p.line_clk;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			c = bp ? p.bp_clk : p.line_clk;
			if (q && !c) return;
			q = c;
		end
		mismatches++;
		stop_test();
	endtask : fall
	task automatic dl_run(input logic [6:0] cfg, input int src);
		logic e;
		logic s;
		int i;
		int k;
		wb(1'b1, ADR_CTRL, {25'h000_0000, cfg}, 4'h1);
		repeat (8) @(posedge clk);
		for (k = 0; k < 6; k++) begin
			fall(1'b0);
			e = src == 1 ? p.fdl_bit : src == 2 ? p.rbit : src == 3 ? p.fs_bit : p.ch24_bit;
			s = src == 4 ? p.ch24_slot : p.dl_slot;
			if (src == 0) begin
				repeat (8) @(posedge clk);
				chk("dl_pins_sf", 2'b00, {dls, dlc});
			end else if (s) begin
				// the previous bit's clock may still stand high here
				repeat (4) @(posedge clk);
				i = 0;
				while (dlc !== 1'b1 && i < 20) begin
					@(posedge clk);
					i++;
				end
				chk("dl_clock", 1'b1, dlc);
				chk("dl_serial", e, dls);
			end
		end
	endtask : dl_run
	task automatic bp_run(input logic [6:0] cfg, input logic dual);
		logic ep;
		logic es;
		int k;
		lp <= cfg[6] | cfg[5];
		wb(1'b1, ADR_CTRL, {25'h000_0000, cfg}, 4'h1);
		repeat (8) @(posedge clk);
		for (k = 0; k < 6; k++) begin
			fall(!(cfg[6] | cfg[5]));
			ep = dual ? p.pos : p.pcm;
			es = dual ? p.neg : p.sig & p.sig_slot;
			repeat (5) @(posedge clk);
			chk("bp_pcm", ep, pcm);
			chk("bp_sig", es, sig);
		end
	endtask : bp_run
	task automatic pulse(input rxdlb_hdlc_evt_t v);
		evt <= v;
		@(posedge clk);
		evt <= '0;
		repeat (3) @(posedge clk);
	endtask : pulse
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk("outs_reset", 4'h0, {dls, dlc, pcm, sig});
		wb(1'b0, ADR_STAT, 32'h0000_0000, 4'h1);
		chk("stat_reset", 4'h0, rd[3:0]);
		wb(1'b0, ADR_CTRL, 32'h0000_0000, 4'h1);
		chk("ctrl_reset", CTRL_RESET, rd);
		wb(1'b1, ADR_CTRL, 32'h0000_0055, 4'h2);
		wb(1'b0, ADR_CTRL, 32'h0000_0000, 4'h1);
		chk("ctrl_no_sel", CTRL_RESET, rd);
		wb(1'b0, 8'h10, 32'h0000_0000, 4'h1);
		chk("unmapped", 32'h0000_0000, rd);
		dl_run(7'h10, 0);
		dl_run(7'h11, 1);
		dl_run(7'h12, 2);
		dl_run(7'h13, 3);
		dl_run(7'h18, 4);
		dl_run(7'h1d, 4);
		wb(1'b0, ADR_STAT, 32'h0000_0000, 4'h1);
		chk("stat_valid", 4'hc, rd[3:0]);
		bp_run(7'h10, 1'b0);
		bp_run(7'h50, 1'b0);
		bp_run(7'h30, 1'b1);
		wb(1'b1, ADR_CTRL, 32'h0000_0015, 4'h1);
		repeat (8) @(posedge clk);
		pulse(3'b100);
		chk("irq_pin", 2'b10, {dls, dlc});
		wb(1'b0, ADR_STAT, 32'h0000_0000, 4'h1);
		chk("stat_flags", 2'b01, rd[1:0]);
		wb(1'b1, ADR_STAT, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge clk);
		chk("irq_clear", 1'b0, dls);
		pulse(3'b010);
		chk("eom_last", 1'b1, dlc);
		wb(1'b1, ADR_STAT, 32'h0000_0002, 4'h1);
		repeat (2) @(posedge clk);
		chk("eom_clear", 1'b0, dlc);
		pulse(3'b001);
		chk("eom_ovr", 1'b1, dlc);
		wb(1'b1, ADR_CTRL, 32'h0000_0001, 4'h1);
		repeat (4) @(posedge clk);
		chk("outs_off", 4'h0, {dls, dlc, pcm, sig});
		stop_test();
	end
endmodule : rxdlb_test
bind rxdlb_top rxdlb_chk i_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
	.WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT), .BP_RX_CLOCK_IN(BP_RX_CLOCK_IN),
	.RECOVERED_LINE_CLOCK_IN(RECOVERED_LINE_CLOCK_IN), .HDLC_EVT_IN(HDLC_EVT_IN),
	.DL_SERIAL_OUT(DL_SERIAL_OUT), .DL_CLOCK_OUT(DL_CLOCK_OUT), .BP_RX_PCM_OUT(BP_RX_PCM_OUT),
	.BP_RX_SIGNALLING_OUT(BP_RX_SIGNALLING_OUT));
